// ==== rtl/dsrl_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsrl_top (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // register port
  input  wire dsrl_pkg::dsrl_bus_s     bus,
  output logic [dsrl_pkg::DW-1:0]      rd_data,
  // drive state
  input  wire dsrl_pkg::dsrl_drive_s   drv,
  input  wire dsrl_pkg::dsrl_speed_t   demand_speed,
  // conditioned setpoint and input roles
  output dsrl_pkg::dsrl_speed_t        setpoint,
  output logic [dsrl_pkg::ICW-1:0]     input_function_code,
  output logic [dsrl_pkg::MDW-1:0]     primary_control_mode,
  // status outputs
  output logic                         relay_logic,
  output logic                         relay_coil,
  output logic                         dig_out
);
  import dsrl_pkg::*;

  function automatic dsrl_speed_t clamp_spd(input dsrl_speed_t v,
                                            input dsrl_speed_t lo,
                                            input dsrl_speed_t hi);
    dsrl_speed_t r;
    r = v;
    if (v < lo) r = lo;
    if (v > hi) r = hi;
    return r;
  endfunction : clamp_spd

  function automatic dsrl_speed_t abs_spd(input dsrl_speed_t v);
    return (v < SPEED_ZERO) ? -v : v;
  endfunction : abs_spd

  function automatic dsrl_pct_t pick_pct(input dsrl_sel_t code,
                                         input dsrl_drive_s d);
    dsrl_pct_t r;
    r = d.speed_pct;
    if (code == FN_TORQUE_LIM) r = d.torque_pct;
    if (code == FN_AIN2_LIM) r = d.ain2_pct;
    return r;
  endfunction : pick_pct

  function automatic logic fn_level(input dsrl_sel_t code,
                                    input logic hyst,
                                    input logic running,
                                    input logic fault,
                                    input logic at_speed,
                                    input logic above_zero);
    logic r;
    r = 1'b0;
    unique case (code)
      FN_ENABLED:    r = running;
      FN_HEALTHY:    r = !fault;
      FN_AT_SPEED:   r = at_speed;
      FN_ABOVE_ZERO: r = above_zero;
      FN_SPEED_LIM,
      FN_TORQUE_LIM,
      FN_AIN2_LIM:   r = hyst;
      default:       r = 1'b0;
    endcase
    return r;
  endfunction : fn_level

  // software settings
  dsrl_sel_t      relay_function_selector;
  dsrl_sel_t      digital_output_selector;
  logic           relay_polarity;
  dsrl_pct_t      relay_high_threshold;
  dsrl_pct_t      relay_low_threshold;
  dsrl_pct_t      digital_output_high_threshold;
  dsrl_pct_t      digital_output_low_threshold;
  dsrl_speed_t    maximum_speed;
  dsrl_speed_t    minimum_speed;
  dsrl_speed_t    zero_speed_threshold;
  dsrl_speed_t    skip_band_centre;
  dsrl_speed_t    skip_band_width;
  logic [PSW-1:0] preset_select;
  logic [DW-1:0]  reg_rd_q;
  logic           mem_rd_sel;

  // address decode
  logic wr_ifc;
  logic wr_mode;
  logic wr_rsel;
  logic wr_rpol;
  logic wr_dsel;
  logic wr_rhi;
  logic wr_rlo;
  logic wr_dhi;
  logic wr_dlo;
  logic wr_max;
  logic wr_min;
  logic wr_zthr;
  logic wr_sctr;
  logic wr_swid;
  logic wr_psel;
  logic pre_hit;
  logic wr_pre;

  assign wr_ifc  = bus.wr && bus.addr == OFS_IFC;
  assign wr_mode = bus.wr && bus.addr == OFS_MODE;
  assign wr_rsel = bus.wr && bus.addr == OFS_RLY_SEL;
  assign wr_rpol = bus.wr && bus.addr == OFS_RLY_POL;
  assign wr_dsel = bus.wr && bus.addr == OFS_DO_SEL;
  assign wr_rhi  = bus.wr && bus.addr == OFS_RLY_HI;
  assign wr_rlo  = bus.wr && bus.addr == OFS_RLY_LO;
  assign wr_dhi  = bus.wr && bus.addr == OFS_DO_HI;
  assign wr_dlo  = bus.wr && bus.addr == OFS_DO_LO;
  assign wr_max  = bus.wr && bus.addr == OFS_MAX_SPD;
  assign wr_min  = bus.wr && bus.addr == OFS_MIN_SPD;
  assign wr_zthr = bus.wr && bus.addr == OFS_ZERO_THR;
  assign wr_sctr = bus.wr && bus.addr == OFS_SKIP_CTR;
  assign wr_swid = bus.wr && bus.addr == OFS_SKIP_WID;
  assign wr_psel = bus.wr && bus.addr == OFS_PRE_SEL;
  assign pre_hit = bus.addr >= OFS_PRE_BASE && bus.addr <= OFS_PRE_LAST
                   && bus.addr[PRE_IDX_LSB-1:0] == '0;
  assign wr_pre  = bus.wr && pre_hit;

  // write values, clamped to their legal ranges
  logic [PAW-1:0]  pre_idx;
  dsrl_speed_t     wr_spd;
  dsrl_pct_t       wr_pct;
  logic [ICW-1:0]  next_ifc;
  logic [MDW-1:0]  next_mode;
  dsrl_speed_t     next_max;
  dsrl_speed_t     next_min;
  dsrl_speed_t     next_zthr;
  dsrl_speed_t     next_sctr;
  dsrl_speed_t     next_swid;
  dsrl_speed_t     next_preset;
  dsrl_speed_t     neg_max;

  assign pre_idx     = PAW'((bus.addr - OFS_PRE_BASE) >> PRE_IDX_LSB);
  assign wr_spd      = dsrl_speed_t'(bus.wdata[SPW-1:0]);
  assign wr_pct      = (bus.wdata > DW'(PCT_MAX)) ? PCT_MAX : bus.wdata[PCW-1:0];
  assign next_ifc    = (bus.wdata > DW'(IFC_MAX)) ? IFC_MAX
                                                  : bus.wdata[ICW-1:0];
  assign next_mode   = (bus.wdata > DW'(MODE_MAX)) ? MODE_MAX
                                                   : bus.wdata[MDW-1:0];
  assign neg_max     = -maximum_speed;
  assign next_max    = (wr_spd < SPEED_ZERO) ? SPEED_ZERO : wr_spd;
  assign next_min    = clamp_spd(wr_spd, SPEED_ZERO, maximum_speed);
  assign next_zthr   = clamp_spd(wr_spd, SPEED_ZERO, maximum_speed);
  assign next_sctr   = clamp_spd(wr_spd, minimum_speed, maximum_speed);
  assign next_swid   = clamp_spd(wr_spd, SPEED_ZERO, maximum_speed);
  assign next_preset = clamp_spd(wr_spd, neg_max, maximum_speed);

  // a low level above the high level would leave no band where the state holds, so it is capped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      relay_high_threshold <= THR_DEF;
      relay_low_threshold  <= THR_DEF;
    end else if (wr_rhi) begin
      relay_high_threshold <= wr_pct;
      if (relay_low_threshold > wr_pct) relay_low_threshold <= wr_pct;
    end else if (wr_rlo) begin
      relay_low_threshold  <= (wr_pct > relay_high_threshold)
                              ? relay_high_threshold : wr_pct;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      digital_output_high_threshold <= THR_DEF;
      digital_output_low_threshold  <= THR_DEF;
    end else if (wr_dhi) begin
      digital_output_high_threshold <= wr_pct;
      if (digital_output_low_threshold > wr_pct) begin
        digital_output_low_threshold <= wr_pct;
      end
    end else if (wr_dlo) begin
      digital_output_low_threshold  <= (wr_pct > digital_output_high_threshold)
                                       ? digital_output_high_threshold : wr_pct;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      input_function_code     <= '0;
      primary_control_mode    <= '0;
      relay_function_selector <= FN_ENABLED;
      digital_output_selector <= FN_ENABLED;
      relay_polarity          <= 1'b0;
      preset_select           <= '0;
    end else begin
      if (wr_ifc)  input_function_code     <= next_ifc;
      if (wr_mode) primary_control_mode    <= next_mode;
      if (wr_rsel) relay_function_selector <= bus.wdata[SELW-1:0];
      if (wr_dsel) digital_output_selector <= bus.wdata[SELW-1:0];
      if (wr_rpol) relay_polarity          <= bus.wdata[0];
      if (wr_psel) preset_select           <= bus.wdata[PSW-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      maximum_speed        <= MAX_SPEED_DEF;
      minimum_speed        <= SPEED_ZERO;
      zero_speed_threshold <= SPEED_ZERO;
      skip_band_centre     <= SPEED_ZERO;
      skip_band_width      <= SPEED_ZERO;
    end else begin
      if (wr_max)  maximum_speed        <= next_max;
      if (wr_min)  minimum_speed        <= next_min;
      if (wr_zthr) zero_speed_threshold <= next_zthr;
      if (wr_sctr) skip_band_centre     <= next_sctr;
      if (wr_swid) skip_band_width      <= next_swid;
    end
  end

  // preset store
  logic           preset_active;
  logic [PAW-1:0] run_idx;
  dsrl_speed_t    pre_bus_q;
  dsrl_speed_t    pre_run_q;

  assign preset_active = preset_select >= PRESET_FIRST
                         && preset_select <= PRESET_LAST;
  assign run_idx       = PAW'(preset_select - PRESET_FIRST);

  dsrl_preset_mem u_presets (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_pre),
    .wr_idx  (pre_idx),
    .wr_data (next_preset),
    .a_idx   (pre_idx),
    .a_q     (pre_bus_q),
    .b_idx   (run_idx),
    .b_q     (pre_run_q)
  );

  // setpoint conditioning; a later drop of the maximum is applied here too
  dsrl_speed_t demand_src;
  dsrl_speed_t demand_lim;
  dsrl_speed_t dem_mag;
  dsrl_speed_t band_half;
  dsrl_speed_t band_lo;
  dsrl_speed_t band_hi;
  logic        in_band;
  logic        take_lo;
  dsrl_speed_t mag_out;
  dsrl_speed_t next_setpoint;

  assign demand_src    = preset_active ? pre_run_q : demand_speed;
  assign demand_lim    = clamp_spd(demand_src, neg_max, maximum_speed);
  assign dem_mag       = abs_spd(demand_lim);
  assign band_half     = skip_band_width >>> SKIP_SHIFT;
  assign band_lo       = skip_band_centre - band_half;
  assign band_hi       = skip_band_centre + band_half;
  assign in_band       = skip_band_width != SPEED_ZERO
                         && dem_mag > band_lo && dem_mag < band_hi;
  assign take_lo       = band_lo >= SPEED_ZERO
                         && (dem_mag - band_lo) <= (band_hi - dem_mag);
  assign mag_out       = in_band ? (take_lo ? band_lo : band_hi) : dem_mag;
  assign next_setpoint = (demand_lim < SPEED_ZERO) ? -mag_out : mag_out;

  // status functions
  logic      at_speed;
  logic      above_zero;
  logic      rly_cmp_en;
  logic      do_cmp_en;
  dsrl_pct_t rly_level;
  dsrl_pct_t do_level;
  logic      rly_hyst_q;
  logic      do_hyst_q;
  logic      next_relay_logic;
  logic      next_dig_out;

  assign at_speed   = drv.motor_speed == setpoint;
  assign above_zero = abs_spd(drv.motor_speed) > zero_speed_threshold;
  assign rly_cmp_en = relay_function_selector >= FN_SPEED_LIM
                      && relay_function_selector <= FN_AIN2_LIM;
  assign do_cmp_en  = digital_output_selector >= FN_SPEED_LIM
                      && digital_output_selector <= FN_AIN2_LIM;
  assign rly_level  = pick_pct(relay_function_selector, drv);
  assign do_level   = pick_pct(digital_output_selector, drv);

  dsrl_hyst u_rly_hyst (
    .ref_clk (ref_clk),
    .rst     (rst),
    .enable  (rly_cmp_en),
    .level   (rly_level),
    .high    (relay_high_threshold),
    .low     (relay_low_threshold),
    .state   (rly_hyst_q)
  );

  dsrl_hyst u_do_hyst (
    .ref_clk (ref_clk),
    .rst     (rst),
    .enable  (do_cmp_en),
    .level   (do_level),
    .high    (digital_output_high_threshold),
    .low     (digital_output_low_threshold),
    .state   (do_hyst_q)
  );

  assign next_relay_logic = fn_level(relay_function_selector, rly_hyst_q,
                                     drv.running, drv.fault, at_speed, above_zero);
  assign next_dig_out     = fn_level(digital_output_selector, do_hyst_q,
                                     drv.running, drv.fault, at_speed, above_zero);

  // coil stays off in reset, so the contacts open whenever logic is unpowered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      relay_logic <= 1'b0;
      relay_coil  <= 1'b0;
      dig_out     <= 1'b0;
      setpoint    <= SPEED_ZERO;
    end else begin
      relay_logic <= next_relay_logic;
      relay_coil  <= next_relay_logic ^ relay_polarity;
      dig_out     <= next_dig_out;
      setpoint    <= next_setpoint;
    end
  end

  // read path
  logic [DW-1:0] status_word;
  logic [DW-1:0] next_rd;

  assign status_word = DW'({do_hyst_q, rly_hyst_q, dig_out, relay_coil, relay_logic});
  assign next_rd =
      (bus.addr == OFS_IFC)      ? DW'(input_function_code) :
      (bus.addr == OFS_MODE)     ? DW'(primary_control_mode) :
      (bus.addr == OFS_RLY_SEL)  ? DW'(relay_function_selector) :
      (bus.addr == OFS_RLY_POL)  ? DW'(relay_polarity) :
      (bus.addr == OFS_DO_SEL)   ? DW'(digital_output_selector) :
      (bus.addr == OFS_RLY_HI)   ? DW'(relay_high_threshold) :
      (bus.addr == OFS_RLY_LO)   ? DW'(relay_low_threshold) :
      (bus.addr == OFS_DO_HI)    ? DW'(digital_output_high_threshold) :
      (bus.addr == OFS_DO_LO)    ? DW'(digital_output_low_threshold) :
      (bus.addr == OFS_MAX_SPD)  ? DW'(unsigned'(maximum_speed)) :
      (bus.addr == OFS_MIN_SPD)  ? DW'(unsigned'(minimum_speed)) :
      (bus.addr == OFS_ZERO_THR) ? DW'(unsigned'(zero_speed_threshold)) :
      (bus.addr == OFS_SKIP_CTR) ? DW'(unsigned'(skip_band_centre)) :
      (bus.addr == OFS_SKIP_WID) ? DW'(unsigned'(skip_band_width)) :
      (bus.addr == OFS_PRE_SEL)  ? DW'(preset_select) :
      (bus.addr == OFS_STATUS)   ? status_word :
      (bus.addr == OFS_SETPOINT) ? DW'(unsigned'(setpoint)) : '0;

  // presets come from the store's own output register, picked one cycle on
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rd_q   <= '0;
      mem_rd_sel <= 1'b0;
    end else begin
      reg_rd_q   <= bus.rd ? next_rd : '0;
      mem_rd_sel <= bus.rd && pre_hit;
    end
  end

  assign rd_data = mem_rd_sel ? DW'(unsigned'(pre_bus_q)) : reg_rd_q;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_rly_above;
    rly_cmp_en && rly_level > relay_high_threshold ##1 rly_cmp_en;
  endsequence

  sequence s_do_above;
    do_cmp_en && do_level > digital_output_high_threshold ##1 do_cmp_en;
  endsequence

  a_relay_run_mode: assert property (
    relay_function_selector == FN_ENABLED |=> relay_logic == $past(drv.running))
    else $error("relay does not follow running");
  a_relay_healthy: assert property (
    relay_function_selector == FN_HEALTHY |=> relay_logic == !$past(drv.fault))
    else $error("relay does not follow fault state");
  a_relay_at_speed: assert property (
    relay_function_selector == FN_AT_SPEED |=> relay_logic == $past(at_speed))
    else $error("relay does not follow at-speed");
  a_relay_above_zero: assert property (
    relay_function_selector == FN_ABOVE_ZERO |=> relay_logic == $past(above_zero))
    else $error("relay does not follow zero speed test");
  a_relay_sets_high: assert property (
    s_rly_above |=> relay_logic)
    else $error("relay not set above high level");
  a_relay_hold_band: assert property (
    rly_cmp_en && rly_level >= relay_low_threshold
    && rly_level <= relay_high_threshold |=> $stable(rly_hyst_q))
    else $error("relay state moved inside band");
  a_dout_sets_high: assert property (
    s_do_above |=> dig_out)
    else $error("digital output not set above high level");
  a_coil_polarity: assert property (
    ##1 relay_coil == (relay_logic ^ $past(relay_polarity)))
    else $error("coil does not match polarity");
  a_ifc_range: assert property (
    input_function_code <= IFC_MAX)
    else $error("input function code out of range");
  a_skip_outside: assert property (
    $stable(skip_band_width) && $stable(skip_band_centre)
    && skip_band_width != SPEED_ZERO |->
    !(abs_spd(setpoint) > band_lo && abs_spd(setpoint) < band_hi))
    else $error("setpoint inside skip band");
endmodule : dsrl_top
`default_nettype wire

// ==== rtl/dsrl_pkg.sv ====
`default_nettype none
package dsrl_pkg;
  localparam int DW   = 32;
  localparam int AW   = 8;
  localparam int SPW  = 16;
  localparam int PCW  = 12;
  localparam int ICW  = 5;
  localparam int SELW = 3;
  localparam int MDW  = 3;
  localparam int PSW  = 4;
  localparam int NPRE = 7;
  localparam int PAW  = 3;
  localparam int PRE_IDX_LSB = 2;
  localparam int SKIP_SHIFT  = 1;

  typedef logic signed [SPW-1:0] dsrl_speed_t;
  typedef logic [PCW-1:0]        dsrl_pct_t;
  typedef logic [SELW-1:0]       dsrl_sel_t;

  typedef enum logic [SELW-1:0] {
    FN_ENABLED    = 3'h0,
    FN_HEALTHY    = 3'h1,
    FN_AT_SPEED   = 3'h2,
    FN_ABOVE_ZERO = 3'h3,
    FN_SPEED_LIM  = 3'h4,
    FN_TORQUE_LIM = 3'h5,
    FN_AIN2_LIM   = 3'h6
  } dsrl_fn_e;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } dsrl_bus_s;

  typedef struct packed {
    logic        running;
    logic        fault;
    dsrl_speed_t motor_speed;
    dsrl_pct_t   speed_pct;
    dsrl_pct_t   torque_pct;
    dsrl_pct_t   ain2_pct;
  } dsrl_drive_s;

  // register byte offsets
  localparam logic [AW-1:0] OFS_IFC       = 8'h00;
  localparam logic [AW-1:0] OFS_MODE      = 8'h04;
  localparam logic [AW-1:0] OFS_RLY_SEL   = 8'h08;
  localparam logic [AW-1:0] OFS_RLY_POL   = 8'h0C;
  localparam logic [AW-1:0] OFS_DO_SEL    = 8'h10;
  localparam logic [AW-1:0] OFS_RLY_HI    = 8'h14;
  localparam logic [AW-1:0] OFS_RLY_LO    = 8'h18;
  localparam logic [AW-1:0] OFS_DO_HI     = 8'h1C;
  localparam logic [AW-1:0] OFS_DO_LO     = 8'h20;
  localparam logic [AW-1:0] OFS_MAX_SPD   = 8'h24;
  localparam logic [AW-1:0] OFS_MIN_SPD   = 8'h28;
  localparam logic [AW-1:0] OFS_ZERO_THR  = 8'h2C;
  localparam logic [AW-1:0] OFS_SKIP_CTR  = 8'h30;
  localparam logic [AW-1:0] OFS_SKIP_WID  = 8'h34;
  localparam logic [AW-1:0] OFS_PRE_SEL   = 8'h38;
  localparam logic [AW-1:0] OFS_PRE_BASE  = 8'h40;
  localparam logic [AW-1:0] OFS_PRE_LAST  = 8'h58;
  localparam logic [AW-1:0] OFS_STATUS    = 8'h60;
  localparam logic [AW-1:0] OFS_SETPOINT  = 8'h64;

  // limits and reset values
  localparam logic [ICW-1:0]  IFC_MAX       = 5'h16;
  localparam logic [MDW-1:0]  MODE_MAX      = 3'h4;
  localparam dsrl_pct_t       PCT_MAX       = 12'h7D0;
  localparam dsrl_pct_t       THR_DEF       = 12'h3E8;
  localparam dsrl_speed_t     MAX_SPEED_DEF = 16'sh01F4;
  localparam dsrl_speed_t     SPEED_ZERO    = 16'sh0000;
  localparam logic [PSW-1:0]  PRESET_FIRST  = 4'h2;
  localparam logic [PSW-1:0]  PRESET_LAST   = 4'h8;

  // status word bit positions
  localparam int ST_RELAY = 0;
  localparam int ST_COIL  = 1;
  localparam int ST_DOUT  = 2;
  localparam int ST_RHYST = 3;
  localparam int ST_DHYST = 4;
endpackage : dsrl_pkg
`default_nettype wire

// ==== rtl/dsrl_hyst.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsrl_hyst (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // comparator
  input  wire logic               enable,
  input  wire dsrl_pkg::dsrl_pct_t level,
  input  wire dsrl_pkg::dsrl_pct_t high,
  input  wire dsrl_pkg::dsrl_pct_t low,
  output logic                    state
);
  import dsrl_pkg::*;

  logic set_hit;
  logic clr_hit;

  assign set_hit = level > high;
  assign clr_hit = level < low;

  // between the two levels nothing fires, so the state holds
  always_ff @(posedge ref_clk) begin
    if (rst || !enable) begin
      state <= 1'b0;
    end else if (set_hit) begin
      state <= 1'b1;
    end else if (clr_hit) begin
      state <= 1'b0;
    end
  end
endmodule : dsrl_hyst
`default_nettype wire

// ==== rtl/dsrl_preset_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsrl_preset_mem (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // write port
  input  wire logic                      wr_en,
  input  wire logic [dsrl_pkg::PAW-1:0]  wr_idx,
  input  wire dsrl_pkg::dsrl_speed_t     wr_data,
  // registered read ports
  input  wire logic [dsrl_pkg::PAW-1:0]  a_idx,
  output dsrl_pkg::dsrl_speed_t          a_q,
  input  wire logic [dsrl_pkg::PAW-1:0]  b_idx,
  output dsrl_pkg::dsrl_speed_t          b_q
);
  import dsrl_pkg::*;

  dsrl_speed_t mem [NPRE];

  genvar gi;
  generate
    for (gi = 0; gi < NPRE; gi++) begin : g_entry
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          mem[gi] <= SPEED_ZERO;
        end else if (wr_en && wr_idx == PAW'(gi)) begin
          mem[gi] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      a_q <= SPEED_ZERO;
      b_q <= SPEED_ZERO;
    end else begin
      a_q <= (int'(a_idx) < NPRE) ? mem[a_idx] : SPEED_ZERO;
      b_q <= (int'(b_idx) < NPRE) ? mem[b_idx] : SPEED_ZERO;
    end
  end
endmodule : dsrl_preset_mem
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dsrl_pkg::*;
  logic          ref_clk = 1'b0;
  logic          rst = 1'b1;
  dsrl_bus_s     bus = '0;
  dsrl_drive_s   drv = '0;
  dsrl_speed_t   demand_speed = '0;
  logic [DW-1:0] rd_data;
  dsrl_speed_t   setpoint;
  logic [ICW-1:0] ifc;
  logic [MDW-1:0] pcm;
  logic          relay_logic;
  logic          relay_coil;
  logic          dig_out;
  logic          pol = 1'b0;
  int            bad_count = 0;
  int            n_tests = 0;

  always #2 ref_clk = ~ref_clk;

  dsrl_top i_dut (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rd_data(rd_data), .drv(drv),
    .demand_speed(demand_speed), .setpoint(setpoint), .input_function_code(ifc),
    .primary_control_mode(pcm), .relay_logic(relay_logic), .relay_coil(relay_coil),
    .dig_out(dig_out));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge ref_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 chk("rd_data", rd_data, e);
  endtask : rdc

  // fixed waits: status outputs settle within two cycles
  task automatic rel(input logic e);
    repeat (3) @(posedge ref_clk);
    #1 chk("relay_logic", relay_logic, e);
    chk("relay_coil", relay_coil, e ^ pol);
    @(posedge ref_clk);
  endtask : rel

  task automatic dck(input logic e);
    repeat (3) @(posedge ref_clk);
    #1 chk("dig_out", dig_out, e);
    @(posedge ref_clk);
  endtask : dck

  task automatic spk(input dsrl_speed_t d, input dsrl_speed_t e);
    @(posedge ref_clk);
    demand_speed <= d;
    repeat (3) @(posedge ref_clk);
    #1 chk("setpoint", {16'h0, setpoint}, {16'h0, e});
  endtask : spk

  // the signals not selected sit at full scale, so a wrong pick sets the relay
  task automatic setp(input int c, input dsrl_pct_t v);
    drv.speed_pct  <= (c == 4) ? v : PCT_MAX;
    drv.torque_pct <= (c == 5) ? v : PCT_MAX;
    drv.ain2_pct   <= (c == 6) ? v : PCT_MAX;
  endtask : setp

  task automatic t_regs;
    rdc(OFS_RLY_HI, 32'h3E8);
    rdc(OFS_PRE_LAST, 32'h0);
    rdc(8'h3C, 32'h0);
    wr(OFS_IFC, 32'h1E);
    rdc(OFS_IFC, 32'h16);
    chk("ifc", {27'h0, ifc}, 32'h16);
    wr(OFS_MODE, 32'h7);
    rdc(OFS_MODE, 32'h4);
    chk("pcm", {29'h0, pcm}, 32'h4);
  endtask : t_regs

  task automatic t_codes;
    wr(OFS_RLY_SEL, 32'h0);
    drv.running <= 1'b1;
    rel(1'b1);
    drv.running <= 1'b0;
    rel(1'b0);
    wr(OFS_RLY_SEL, 32'h1);
    rel(1'b1);
    drv.fault <= 1'b1;
    rel(1'b0);
    wr(OFS_RLY_SEL, 32'h2);
    demand_speed <= 16'sh0064;
    drv.motor_speed <= 16'sh0064;
    rel(1'b1);
    drv.motor_speed <= 16'sh0063;
    rel(1'b0);
    wr(OFS_RLY_SEL, 32'h3);
    wr(OFS_ZERO_THR, 32'h32);
    drv.motor_speed <= 16'sh0033;
    rel(1'b1);
    drv.motor_speed <= 16'sh0032;
    rel(1'b0);
  endtask : t_codes

  task automatic t_hyst;
    for (int c = 4; c <= 6; c++) begin
      pol = (c == 5);
      wr(OFS_RLY_POL, {31'h0, pol});
      wr(OFS_RLY_SEL, c);
      wr(OFS_RLY_HI, 32'h4B0);
      wr(OFS_RLY_LO, 32'h320);
      setp(c, 12'h0);
      rel(1'b0);
      setp(c, 12'h4B0);
      rel(1'b0);
      setp(c, 12'h4B1);
      rel(1'b1);
      setp(c, 12'h320);
      rel(1'b1);
      setp(c, 12'h31F);
      rel(1'b0);
      setp(c, 12'h3E8);
      rel(1'b0);
    end
    wr(OFS_DO_SEL, 32'h4);
    wr(OFS_DO_HI, 32'h1F4);
    wr(OFS_DO_LO, 32'h64);
    drv.speed_pct <= 12'h63;
    dck(1'b0);
    drv.speed_pct <= 12'h1F4;
    dck(1'b0);
    drv.speed_pct <= 12'h1F5;
    dck(1'b1);
    drv.speed_pct <= 12'h64;
    dck(1'b1);
    drv.speed_pct <= 12'h63;
    dck(1'b0);
  endtask : t_hyst

  task automatic t_speed;
    wr(OFS_PRE_BASE, 32'h258);
    rdc(OFS_PRE_BASE, 32'h1F4);
    wr(OFS_PRE_BASE + 8'h04, 32'hFFFFFDA8);
    rdc(OFS_PRE_BASE + 8'h04, 32'hFE0C);
    wr(OFS_PRE_SEL, 32'h3);
    spk(16'sh0000, 16'shFE0C);
    wr(OFS_PRE_SEL, 32'h0);
    wr(OFS_MIN_SPD, 32'h64);
    wr(OFS_SKIP_CTR, 32'h32);
    rdc(OFS_SKIP_CTR, 32'h64);
    wr(OFS_SKIP_CTR, 32'h2BC);
    rdc(OFS_SKIP_CTR, 32'h1F4);
    wr(OFS_SKIP_WID, 32'h384);
    rdc(OFS_SKIP_WID, 32'h1F4);
    wr(OFS_SKIP_CTR, 32'hC8);
    wr(OFS_SKIP_WID, 32'h28);
    spk(16'sh00BE, 16'sh00B4);
    spk(16'sh00D7, 16'sh00DC);
    spk(16'sh00E6, 16'sh00E6);
  endtask : t_speed

  initial begin
    repeat (15) @(posedge ref_clk);
    #1 chk("relay_coil", relay_coil, 1'b0);
    @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_codes();
    t_hyst();
    t_speed();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
